/* ufsd_params.svh */
/*
 * Constants of the full-speed device port: endpoint layout and timing.
 * Assumes the system clock figure below matches i_sys_clk.
 */
`ifndef UFSD_PARAMS_SVH
`define UFSD_PARAMS_SVH
`define UFSD_CLK_MHZ    100
`define UFSD_EP_N       8
`define UFSD_EP_BYTES   7'h40
`define UFSD_EP0_BYTES  7'h08
`define UFSD_DUAL_MAP   8'hf6
`define UFSD_SUSP_MS    3
`define UFSD_SUSP_CYC   (`UFSD_SUSP_MS * `UFSD_CLK_MHZ * 1000)
`define UFSD_WAKE_MS    10
`define UFSD_WAKE_CYC   (`UFSD_WAKE_MS * `UFSD_CLK_MHZ * 1000)
`define UFSD_RES_NS     100
`define UFSD_RES_CYC    ((`UFSD_RES_NS * `UFSD_CLK_MHZ + 999) / 1000)
`define UFSD_DIV48_LAST 2'h3
`define UFSD_IRQ_N      10
`endif

/* ufsd_pkg.sv */
/*
 * Types of the full-speed device port.
 * Assumes nothing of its surroundings.
 */
package ufsd_pkg;
	typedef enum logic [1:0] {EPT_CTRL, EPT_BULK, EPT_ISO, EPT_INTR} ufsd_ept_e;
	typedef enum logic [1:0] {LS_ACTIVE, LS_SUSPENDED, LS_WAKING} ufsd_lst_e;
	// One byte access or bank hand-over on a buffer side
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       commit;
		logic [2:0] ep;
		logic [7:0] wdata;
	} ufsd_port_s;
	// Pad drive request of the serial engine
	typedef struct packed {
		logic en;
		logic dp;
		logic dm;
	} ufsd_tx_s;
endpackage : ufsd_pkg

/* ufsd_port.sv */
/*
 * Full-speed device port core: endpoint bank buffers, suspend/resume
 * monitor, remote wake, pad control and interrupt line.
 * Assumes the serial engine and processor sit on i_sys_clk; pads, the
 * 48 MHz clock and the wake strap are asynchronous.
 */
// Notes on behaviour
// - Each endpoint takes one of several standard transfer types.
// - Each endpoint holds its packet in one or two RAM banks.
// - Dual-bank: processor uses one bank while engine uses the other.
// - Isochronous traffic only on dual-bank endpoints.
// - Endpoints 0,3 single bank, endpoint 0 8 bytes; others dual 64.
// - Two banks let the port sustain full bus throughput.
// - Suspend and resume detected on their own, each raises an interrupt.
// - Buffer data moves one byte per access.
// - Register side on master clock, bus side timed by 48 MHz clock.
// - The pad is driven and sampled under engine control; during remote wake the port drives K over the engine.
// - Optional external wake asks the host for resume when agreed.
// - Only this port drives the D+ and D- lines.
// - One interrupt output goes to the interrupt controller.
// - Control transfers only on single-bank endpoints.
`timescale 1ns/10ps
`default_nettype none
`include "ufsd_params.svh"
module ufsd_port
	import ufsd_pkg::*;
#(
	parameter int SUSP_CYC = `UFSD_SUSP_CYC,
	parameter int WAKE_CYC = `UFSD_WAKE_CYC
) (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst,
	input  wire logic                    i_usb_48mhz_clock,
	input  wire ufsd_port_s              i_cpu,
	output logic       [7:0]             o_cpu_rdata,
	output logic       [6:0]             o_cpu_cnt,
	output logic                         o_cpu_busy,
	input  wire ufsd_port_s              i_sie,
	output logic       [7:0]             o_sie_rdata,
	output logic       [6:0]             o_sie_cnt,
	output logic                         o_sie_avail,
	input  wire ufsd_ept_e [7:0]         i_ep_type,
	output logic       [7:0]             o_ep_cfg_err,
	input  wire ufsd_tx_s                i_sie_tx,
	input  wire logic                    i_dp_in,
	input  wire logic                    i_dm_in,
	output logic                         o_dp_out,
	output logic                         o_dp_oe,
	output logic                         o_dm_out,
	output logic                         o_dm_oe,
	output logic       [1:0]             o_line,
	output logic                         o_bit_tick,
	input  wire logic                    i_ext_wake,
	input  wire logic                    i_wake_en,
	output logic                         o_suspended,
	input  wire logic [`UFSD_IRQ_N-1:0]  i_irq_clr,
	output logic      [`UFSD_IRQ_N-1:0]  o_irq_flags,
	output logic                         o_irq
);
	localparam int RES_CYC = `UFSD_RES_CYC;

	// Counter is 21 bits; longer times cannot be served
	if (SUSP_CYC < 2 || SUSP_CYC > 2000000 || WAKE_CYC < 2 || WAKE_CYC > 2000000) begin : g_bad
		$error("ufsd_port: timing parameter out of range");
	end

	logic [2:0] c48_ff;
	logic [1:0] dp_ff, dm_ff, wk_ff;
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			c48_ff <= 3'h0;
			dp_ff  <= 2'h0;
			dm_ff  <= 2'h0;
			wk_ff  <= 2'h0;
		end else begin
			c48_ff <= {c48_ff[1:0], i_usb_48mhz_clock};
			dp_ff  <= {dp_ff[0], i_dp_in};
			dm_ff  <= {dm_ff[0], i_dm_in};
			wk_ff  <= {wk_ff[0], i_ext_wake};
		end
	end

	logic [1:0] div_ff, nxt_div;
	logic       tick_ff, nxt_tick;
	always_comb begin
		nxt_div  = div_ff;
		nxt_tick = 1'b0;
		if (c48_ff[1] && !c48_ff[2]) begin
			nxt_div  = div_ff + 2'h1;
			nxt_tick = (div_ff == `UFSD_DIV48_LAST);
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_ff  <= 2'h0;
			tick_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			tick_ff <= nxt_tick;
		end
	end
	assign o_bit_tick = tick_ff;

	// Line monitor: J idle, K resume
	logic       ln_j, ln_k;
	ufsd_lst_e  st_ff, nxt_st;
	logic [20:0] cnt_ff, nxt_cnt;
	logic       ev_susp, ev_res;
	assign ln_j = dp_ff[1] && !dm_ff[1];
	assign ln_k = !dp_ff[1] && dm_ff[1];
	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff + 21'h1;
		ev_susp = 1'b0;
		ev_res  = 1'b0;
		unique case (st_ff)
			LS_ACTIVE: begin
				if (!ln_j) begin
					nxt_cnt = 21'h0;
				end else if (cnt_ff == 21'(SUSP_CYC - 1)) begin
					nxt_st  = LS_SUSPENDED;
					nxt_cnt = 21'h0;
					ev_susp = 1'b1;
				end
			end
			LS_SUSPENDED: begin
				if (ln_k && cnt_ff == 21'(RES_CYC - 1)) begin
					nxt_st  = LS_ACTIVE;
					nxt_cnt = 21'h0;
					ev_res  = 1'b1;
				end else if (ln_k) begin
					nxt_cnt = cnt_ff + 21'h1;
				end else if (i_wake_en && wk_ff[1]) begin
					nxt_st  = LS_WAKING;
					nxt_cnt = 21'h0;
				end else begin
					nxt_cnt = 21'h0;
				end
			end
			LS_WAKING: begin
				if (cnt_ff == 21'(WAKE_CYC - 1)) begin
					nxt_st  = LS_ACTIVE;
					nxt_cnt = 21'h0;
				end
			end
		endcase
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			st_ff  <= LS_ACTIVE;
			cnt_ff <= 21'h0;
		end else begin
			st_ff  <= nxt_st;
			cnt_ff <= nxt_cnt;
		end
	end
	assign o_suspended = (st_ff != LS_ACTIVE);

	// Pad drive; wake K overrides the engine
	logic [3:0] pad_ff, nxt_pad;
	logic [1:0] line_ff;
	always_comb begin
		nxt_pad = {i_sie_tx.dp, i_sie_tx.en, i_sie_tx.dm, i_sie_tx.en};
		if (nxt_st == LS_WAKING) begin
			nxt_pad = 4'h7;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pad_ff  <= 4'h0;
			line_ff <= 2'h0;
		end else begin
			pad_ff  <= nxt_pad;
			line_ff <= {dp_ff[1], dm_ff[1]};
		end
	end
	assign {o_dp_out, o_dp_oe, o_dm_out, o_dm_oe} = pad_ff;
	assign o_line = line_ff;

	// Endpoint type check against bank count
	logic [7:0] dual, cfg_ff, nxt_cfg;
	assign dual = `UFSD_DUAL_MAP;
	for (genvar g = 0; g < `UFSD_EP_N; g++) begin : g_cfg
		assign nxt_cfg[g] = (i_ep_type[g] == EPT_ISO && !dual[g]) ||
			(i_ep_type[g] == EPT_CTRL && dual[g]);
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cfg_ff <= 8'h00;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end
	assign o_ep_cfg_err = cfg_ff;

	logic [7:0]  mem [0:1023];
	logic [15:0] own_ff, nxt_own;
	logic [7:0]  csel_ff, nxt_csel, usel_ff, nxt_usel, ev_ret;
	logic [6:0]  cptr_ff [8], nxt_cptr [8], uptr_ff [8], nxt_uptr [8];
	logic [6:0]  bcnt_ff [16], nxt_bcnt [16];
	logic [3:0]  cb, ub;
	logic        cok, uok;
	logic [6:0]  clim, ulim;
	assign cb   = {i_cpu.ep, csel_ff[i_cpu.ep]};
	assign ub   = {i_sie.ep, usel_ff[i_sie.ep]};
	assign clim = (i_cpu.ep == 3'h0) ? `UFSD_EP0_BYTES : `UFSD_EP_BYTES;
	assign ulim = (i_sie.ep == 3'h0) ? `UFSD_EP0_BYTES : `UFSD_EP_BYTES;
	assign cok  = !own_ff[cb] && !cfg_ff[i_cpu.ep];
	assign uok  = own_ff[ub] && !cfg_ff[i_sie.ep];
	assign o_cpu_busy  = !cok;
	assign o_sie_avail = uok;
	always_comb begin
		nxt_own  = own_ff;
		nxt_csel = csel_ff;
		nxt_usel = usel_ff;
		nxt_cptr = cptr_ff;
		nxt_uptr = uptr_ff;
		nxt_bcnt = bcnt_ff;
		ev_ret   = 8'h00;
		if (cok && (i_cpu.wr || i_cpu.rd) && cptr_ff[i_cpu.ep] < clim) begin
			nxt_cptr[i_cpu.ep] = cptr_ff[i_cpu.ep] + 7'h1;
		end
		if (cok && i_cpu.commit) begin
			nxt_own[cb]        = 1'b1;
			nxt_bcnt[cb]       = cptr_ff[i_cpu.ep];
			nxt_cptr[i_cpu.ep] = 7'h0;
			nxt_csel[i_cpu.ep] = csel_ff[i_cpu.ep] ^ dual[i_cpu.ep];
		end
		if (uok && (i_sie.wr || i_sie.rd) && uptr_ff[i_sie.ep] < ulim) begin
			nxt_uptr[i_sie.ep] = uptr_ff[i_sie.ep] + 7'h1;
		end
		if (uok && i_sie.commit) begin
			nxt_own[ub]        = 1'b0;
			nxt_bcnt[ub]       = uptr_ff[i_sie.ep];
			nxt_uptr[i_sie.ep] = 7'h0;
			nxt_usel[i_sie.ep] = usel_ff[i_sie.ep] ^ dual[i_sie.ep];
			ev_ret[i_sie.ep]   = 1'b1;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			own_ff  <= 16'h0000;
			csel_ff <= 8'h00;
			usel_ff <= 8'h00;
			cptr_ff <= '{default: 7'h0};
			uptr_ff <= '{default: 7'h0};
			bcnt_ff <= '{default: 7'h0};
		end else begin
			own_ff  <= nxt_own;
			csel_ff <= nxt_csel;
			usel_ff <= nxt_usel;
			cptr_ff <= nxt_cptr;
			uptr_ff <= nxt_uptr;
			bcnt_ff <= nxt_bcnt;
		end
	end
	assign o_cpu_cnt = bcnt_ff[cb];
	assign o_sie_cnt = bcnt_ff[ub];

	// Dual-port RAM; owners never share a bank
	logic [7:0] crd_ff, urd_ff;
	always_ff @(posedge i_sys_clk) begin
		if (cok && i_cpu.wr && cptr_ff[i_cpu.ep] < clim) begin
			mem[{cb, cptr_ff[i_cpu.ep][5:0]}] <= i_cpu.wdata;
		end
		if (uok && i_sie.wr && uptr_ff[i_sie.ep] < ulim) begin
			mem[{ub, uptr_ff[i_sie.ep][5:0]}] <= i_sie.wdata;
		end
		if (i_rst) begin
			crd_ff <= 8'h00;
			urd_ff <= 8'h00;
		end else begin
			if (cok && i_cpu.rd) begin
				crd_ff <= mem[{cb, cptr_ff[i_cpu.ep][5:0]}];
			end
			if (uok && i_sie.rd) begin
				urd_ff <= mem[{ub, uptr_ff[i_sie.ep][5:0]}];
			end
		end
	end
	assign o_cpu_rdata = crd_ff;
	assign o_sie_rdata = urd_ff;

	// Sticky events; a set in the clear cycle wins
	logic [9:0] irq_ff, nxt_irq;
	always_comb begin
		nxt_irq = (irq_ff & ~i_irq_clr) | {ev_ret, ev_res, ev_susp};
	end
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			irq_ff <= 10'h000;
		end else begin
			irq_ff <= nxt_irq;
		end
	end
	assign o_irq_flags = irq_ff;
	assign o_irq = |irq_ff;

	default clocking cb_sys @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	sequence s_wake_go;
		st_ff == LS_SUSPENDED && i_wake_en && wk_ff[1] && !ln_k;
	endsequence
	sequence s_k_drive;
		o_dp_oe && o_dm_oe && !o_dp_out && o_dm_out;
	endsequence
	susp_event_a: assert property ($rose(o_suspended) && st_ff == LS_SUSPENDED |-> o_irq_flags[0])
		else $error("suspend did not flag");
	res_event_a: assert property (st_ff == LS_SUSPENDED ##1 st_ff == LS_ACTIVE |-> o_irq_flags[1] && o_irq)
		else $error("resume did not flag");
	wake_drive_a: assert property (s_wake_go |=> ##1 s_k_drive [*8])
		else $error("wake K not driven");
	pad_owner_a: assert property (o_dp_oe |-> $past(i_sie_tx.en) || st_ff == LS_WAKING)
		else $error("pad driven without owner");
	iso_single_a: assert property (i_ep_type[0] == EPT_ISO |=> o_ep_cfg_err[0])
		else $error("iso accepted on single bank");
	ctrl_dual_a: assert property (i_ep_type[1] == EPT_CTRL |=> o_ep_cfg_err[1] && (!o_sie_avail || i_sie.ep != 3'h1))
		else $error("control accepted on dual bank");
	pingpong_a: assert property (cok && i_cpu.commit && dual[i_cpu.ep] |=> csel_ff != $past(csel_ff))
		else $error("dual bank did not swap");
	single_bank_a: assert property (csel_ff[0] == 1'b0 && csel_ff[3] == 1'b0 && usel_ff[3] == 1'b0)
		else $error("single bank endpoint swapped");
	bit_tick_a: assert property (o_bit_tick |=> !o_bit_tick [*2])
		else $error("bit tick too fast");
	irq_line_a: assert property (ev_susp |=> o_irq)
		else $error("interrupt line stayed low");
endmodule : ufsd_port
`default_nettype wire

/* ufsd_host_model.sv */
/*
 Host end of the full-speed bus: idles J, sends K or SE0 when asked.
 Assumes device pads drive the wire whenever their enable is high.
*/
`timescale 1ns/10ps
`default_nettype none
module ufsd_host_model (
	input  wire logic i_dp_out,
	input  wire logic i_dp_oe,
	input  wire logic i_dm_out,
	input  wire logic i_dm_oe,
	input  wire logic i_send_k,
	input  wire logic i_se0,
	output logic      o_dp,
	output logic      o_dm
);
	// Wire level from host idle or K, device drive wins
	always_comb begin
		o_dp = ~i_send_k;
		o_dm = i_send_k;
		// host busy or off: SE0 keeps the idle timer still
		if (i_se0) begin
			o_dp = 1'b0;
			o_dm = 1'b0;
		end
		if (i_dp_oe) o_dp = i_dp_out;
		if (i_dm_oe) o_dm = i_dm_out;
	end
endmodule : ufsd_host_model
`default_nettype wire

/* usb_full_speed_device_port_tb_top.sv */
/*
 Self-checking bench of the device port with a host line model.
 Assumes short suspend and wake counts set through parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module usb_full_speed_device_port_tb_top;
	import ufsd_pkg::*;
	logic             i_sys_clk = 0, i_rst = 1, clk48 = 0, send_k = 0, dp, dm;
	logic             i_ext_wake = 0, i_wake_en = 0, se0 = 1;
	ufsd_port_s       i_cpu = '0, i_sie = '0;
	ufsd_tx_s         i_sie_tx = '0;
	ufsd_ept_e [7:0]  ep_type = '{0: EPT_CTRL, default: EPT_BULK};
	logic [9:0]       i_irq_clr = '0;
	logic [7:0]       cpu_rd, sie_rd, cfg_err;
	logic [6:0]       cpu_cnt, sie_cnt;
	logic [9:0]       flags;
	logic [1:0]       line;
	logic             busy, avail, dpo, dpe, dmo, dme, tick, susp, irq;
	int               err_count = 0, checked = 0, n;
	always #5 i_sys_clk = ~i_sys_clk;
	always #10.4167 clk48 = ~clk48;
	ufsd_port #(.SUSP_CYC(20), .WAKE_CYC(16)) u_ufsd_port (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
		.i_usb_48mhz_clock(clk48), .i_cpu(i_cpu), .o_cpu_rdata(cpu_rd), .o_cpu_cnt(cpu_cnt),
		.o_cpu_busy(busy), .i_sie(i_sie), .o_sie_rdata(sie_rd), .o_sie_cnt(sie_cnt),
		.o_sie_avail(avail), .i_ep_type(ep_type), .o_ep_cfg_err(cfg_err), .i_sie_tx(i_sie_tx),
		.i_dp_in(dp), .i_dm_in(dm), .o_dp_out(dpo), .o_dp_oe(dpe), .o_dm_out(dmo), .o_dm_oe(dme),
		.o_line(line), .o_bit_tick(tick), .i_ext_wake(i_ext_wake), .i_wake_en(i_wake_en),
		.o_suspended(susp), .i_irq_clr(i_irq_clr), .o_irq_flags(flags), .o_irq(irq));
	ufsd_host_model u_ufsd_host_model (.i_dp_out(dpo), .i_dp_oe(dpe), .i_dm_out(dmo),
		.i_dm_oe(dme), .i_send_k(send_k), .i_se0(se0), .o_dp(dp), .o_dm(dm));

	task check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One strobe cycle on the processor or engine side
	task op(input bit serial_interface_engine, input ufsd_port_s v);
		@(posedge i_sys_clk);
		if (serial_interface_engine) i_sie <= v; else i_cpu <= v;
		@(posedge i_sys_clk);
		if (serial_interface_engine) i_sie <= '0; else i_cpu <= '0;
		#1;
	endtask : op

	task clr_flags;
		@(posedge i_sys_clk) i_irq_clr <= '1;
		@(posedge i_sys_clk) i_irq_clr <= '0;
		repeat (2) @(posedge i_sys_clk);
		#1 check(irq, 0);
	endtask : clr_flags

	// Ping-pong packet on endpoint 1
	task t_dual;
		op(0, '{1, 0, 0, 1, 8'haa});
		op(0, '{1, 0, 0, 1, 8'hbb});
		op(0, '{0, 0, 1, 1, 8'h00});
		@(posedge i_sys_clk) {i_cpu.ep, i_sie.ep} <= 6'h09;
		#1 check(busy, 0);
		check(avail, 1);
		check(sie_cnt, 2);
		op(0, '{1, 0, 0, 1, 8'h11});
		op(1, '{0, 1, 0, 1, 8'h00});
		@(posedge i_sys_clk) #1 check(sie_rd, 8'haa);
		op(1, '{0, 1, 0, 1, 8'h00});
		@(posedge i_sys_clk) #1 check(sie_rd, 8'hbb);
		op(1, '{0, 0, 1, 1, 8'h00});
		@(posedge i_sys_clk) #1 check(flags, 10'h008);
		check(irq, 1);
		// Processor hands bank 1 over and gets bank 0 back
		op(0, '{0, 0, 1, 1, 8'h00});
		@(posedge i_sys_clk) i_cpu.ep <= 3'h1;
		#1 check(cpu_cnt, 2);
		op(0, '{0, 1, 0, 1, 8'h00});
		@(posedge i_sys_clk) #1 check(cpu_rd, 8'haa);
		clr_flags();
	endtask : t_dual

	// Endpoint 0 holds 8 bytes, then stays with the engine
	task t_single;
		for (int i = 0; i < 9; i++) op(0, '{1, 0, 0, 0, 8'h30});
		op(0, '{0, 0, 1, 0, 8'h00});
		@(posedge i_sys_clk) #1 check(busy, 1);
		check(sie_cnt, 8);
		// Engine overwrites one byte and returns the bank with that count
		op(1, '{1, 0, 0, 0, 8'h5a});
		op(1, '{0, 0, 1, 0, 8'h00});
		@(posedge i_sys_clk) #1 check(flags, 10'h004);
		check(busy, 0);
		check(cpu_cnt, 1);
		op(0, '{0, 1, 0, 0, 8'h00});
		@(posedge i_sys_clk) #1 check(cpu_rd, 8'h5a);
		clr_flags();
	endtask : t_single

	// Iso on a single bank, control on a dual bank
	task t_cfg;
		@(posedge i_sys_clk);
		ep_type[0] <= EPT_ISO;
		ep_type[1] <= EPT_CTRL;
		ep_type[2] <= EPT_INTR;
		repeat (3) @(posedge i_sys_clk);
		#1 check(cfg_err, 8'h03);
		check(busy, 1);
		@(posedge i_sys_clk);
		ep_type[0] <= EPT_CTRL;
		ep_type[1] <= EPT_ISO;
		repeat (3) @(posedge i_sys_clk);
		#1 check(cfg_err, 8'h00);
	endtask : t_cfg

	task t_pads;
		@(posedge i_sys_clk) i_sie_tx <= '{1, 0, 1};
		repeat (2) @(posedge i_sys_clk);
		#1 check({dpe, dme, dpo, dmo}, 4'hd);
		@(posedge i_sys_clk) i_sie_tx <= '0;
		repeat (2) @(posedge i_sys_clk);
		#1 check({dpe, dme}, 0);
		n = 0;
		repeat (200) begin
			@(posedge i_sys_clk);
			#1 n += tick;
		end
		check(n >= 23 && n <= 25, 1);
	endtask : t_pads

	task wait_flag(input int b);
		for (int i = 0; i < 200 && flags[b] !== 1'b1; i++) @(posedge i_sys_clk);
		#1 check(flags[b], 1);
	endtask : wait_flag

	// Suspend, remote wake, suspend again, host resume
	task t_line;
		// Host stops traffic; the line idles at J unless a K is driven
		@(posedge i_sys_clk) se0 <= 1'b0;
		wait_flag(0);
		check(susp, 1);
		check(line, 2'h2);
		clr_flags();
		@(posedge i_sys_clk) {i_wake_en, i_ext_wake} <= 2'h3;
		for (int i = 0; i < 20 && dpe !== 1'b1; i++) @(posedge i_sys_clk);
		#1 check({dpe, dme, dpo, dmo}, 4'hd);
		@(posedge i_sys_clk) {i_wake_en, i_ext_wake} <= 2'h0;
		repeat (24) @(posedge i_sys_clk);
		#1 check(dpe, 0);
		clr_flags();
		wait_flag(0);
		@(posedge i_sys_clk) send_k <= 1;
		wait_flag(1);
		check(susp, 0);
		@(posedge i_sys_clk) send_k <= 0;
	endtask : t_line

	task complete_run;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_rst <= 0;
		// interrupt line quiet before any endpoint use
		#1 check({flags, irq, busy, avail, dpe, dme, susp}, 0);
		t_dual();
		t_single();
		t_cfg();
		t_pads();
		t_line();
		complete_run();
	end

	initial begin
		#200000;
		err_count++;
		complete_run();
	end
endmodule : usb_full_speed_device_port_tb_top
`default_nettype wire
